// ### rtl/mcsr_core.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// - Accesses to the pointer location reach the data word chosen by bank select.
// - Timer counts instruction cycles or chosen-polarity edges on its pin.
// - Software reads and writes the timer like any data register.
// - Prescaler clears on timer write, timer control write and every reset.
// - Program counter and every stack entry are twelve bits wide.
// - Program space is 2K words, split into 1024-word pages.
// - Every reset condition clears the program counter.
// - Jump loads the low ten counter bits from the operand.
// - Call loads the low ten bits and pushes the next address.
// - The return form reloads the counter from the stack top.
// - Accumulator add to the counter carries into bits eight and nine; bit ten takes page select.
// - Moving into the counter low byte keeps bits eight and nine.
// - Any other counter-low write also keeps bits eight and nine.
// - Jump, call and counter writes copy page select into bit ten.
// - Cycle is two or four clocks; counter writes may add a cycle.
// - Wake bit set on wake-from-sleep, cleared for other reset causes.
// - Segment bit chooses control space segment zero or one.
// - Returns never alter page select.
// - Time-out bit set by sleep, watchdog clear, power-on; cleared by time-out.
// - Power-down bit set by power-on and watchdog clear, cleared by sleep.
// - Zero flag set on zero result; bit one aux carry, bit zero carry.
// - Bank select bit seven reads zero, bit six bank, bits 5..0 address.
module mcsr_core
	import mcsr_pkg::*;
(
	input  wire logic              mclk_in,         // Oscillator clock
	input  wire logic              rstn_in,         // Power-on reset, low
	input  wire mcsr_reg_req_t     reg_req_in,      // Register port request
	output logic [DATA_W-1:0]      rd_data_out,     // Read data, next cycle
	input  wire mcsr_instr_t       instr_in,        // Instruction this cycle
	input  wire mcsr_alu_t         alu_in,          // ALU flag result
	input  wire logic              reset_event_in,  // Non-power-on reset pulse
	input  wire mcsr_reset_cause_t reset_cause_in,  // Cause of reset_event_in
	input  wire logic              tcc_pin_in,      // External counter input
	input  wire logic              clk_div_sel_in,  // 0: 2 clocks, 1: 4 clocks
	input  wire logic              cycle_opt_in,    // 1: counter writes add one
	output logic                   cycle_tick_out,  // Instruction taken now
	output logic [PROG_W-1:0]      prog_addr_out,   // Program memory address
	output logic [DATA_W-1:0]      status_out,      // Status flags
	output logic [DATA_W-1:0]      timer_value_out  // Timer count
);

	////////////////////////////////////////////////////////////////////////
	// Address helpers, shared by the read and the write path.

	// A pointer location in the target falls back to itself, which has no
	// storage, so a pointer that names the pointer reads zero.
	function automatic logic [5:0] mcsr_resolve(
		input logic [5:0]        a,
		input logic [DATA_W-1:0] sel
	);
		return (a == ADDR_INDIRECT) ? sel[5:0] : a;
	endfunction : mcsr_resolve

	function automatic logic [RAM_IDX_W-1:0] mcsr_ram_index(
		input logic [5:0] a,
		input logic       bank
	);
		logic [RAM_IDX_W-1:0] ofs;
		ofs = 7'(a);
		if (a < ADDR_BANK_BASE) begin
			return ofs - 7'(ADDR_GEN_BASE);
		end
		return GEN_WORDS + (bank ? BANK_WORDS : 7'h00)
			+ (ofs - 7'(ADDR_BANK_BASE));
	endfunction : mcsr_ram_index

	////////////////////////////////////////////////////////////////////////
	// State.

	mcsr_state_t s_reg;
	mcsr_state_t s_next;

	logic                 take;
	logic                 div_wrap;
	logic                 is_ctrl;
	logic [5:0]           ctrl_ofs;
	logic [5:0]           target;
	logic                 is_ram;
	logic [RAM_IDX_W-1:0] ram_idx;
	logic                 bank;
	logic                 seg;
	logic                 pin_edge;
	logic                 count_evt;
	logic [7:0]           psc_mask;
	logic                 psc_hit;
	logic                 tcc_wr;
	logic                 tctrl_wr;
	logic                 pc_wr;
	logic [PC_W-1:0]      pc_inc;
	logic                 page;

	assign take     = s_reg.tick;
	assign div_wrap = s_reg.div == (clk_div_sel_in ? DIV4_LAST : DIV2_LAST);
	assign is_ctrl  = reg_req_in.addr[ADDR_CTRL_BIT];
	assign ctrl_ofs = reg_req_in.addr[5:0];
	assign target   = mcsr_resolve(reg_req_in.addr[5:0], s_reg.ram_sel);
	assign is_ram   = target >= ADDR_GEN_BASE;
	assign bank     = s_reg.ram_sel[RAM_SEL_BANK];
	assign ram_idx  = mcsr_ram_index(target, bank);
	assign seg      = s_reg.status[ST_SEG];
	assign page     = s_reg.status[ST_PAGE];
	assign pc_inc   = s_reg.pc + 12'h001;

	// Control space holds the timer control in segment zero and the
	// prescaler count in segment one; other offsets are unbacked here.
	assign tctrl_wr = reg_req_in.wr && is_ctrl && !seg
		&& ctrl_ofs == CTRL_TIMER_OFS;
	assign tcc_wr   = reg_req_in.wr && !is_ctrl && target == ADDR_TIMER;
	assign pc_wr    = reg_req_in.wr && !is_ctrl && target == ADDR_PC_LOW;

	////////////////////////////////////////////////////////////////////////
	// Timer event selection and prescaler.

	// Edge select low counts rising edges, high counts falling edges.
	assign pin_edge = s_reg.tctrl[TC_EDGE]
		? (s_reg.pin_prev && !tcc_pin_in)
		: (!s_reg.pin_prev && tcc_pin_in);
	assign count_evt = s_reg.tctrl[TC_SRC] ? pin_edge : take;

	// Ratio is two to the power of the select field plus one.
	assign psc_mask = 8'((9'h002 << s_reg.tctrl[2:0]) - 9'h001);
	assign psc_hit  = s_reg.tctrl[TC_BYPASS]
		|| ((s_reg.psc | ~psc_mask) == 8'hFF);

	////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		s_next = s_reg;
		s_next.pin_prev = tcc_pin_in;

		// Instruction cycle strobe; a counter write may swallow one strobe.
		s_next.div  = div_wrap ? 2'h0 : s_reg.div + 2'h1;
		s_next.tick = div_wrap && !s_reg.skip;
		if (div_wrap && s_reg.skip) begin
			s_next.skip = 1'b0;
		end

		// Timer and prescaler counting.
		if (count_evt) begin
			if (psc_hit) begin
				s_next.psc = 8'h00;
				s_next.time_clock_counter = s_reg.time_clock_counter + 8'h01;
			end else begin
				s_next.psc = s_reg.psc + 8'h01;
			end
		end

		// Program counter sequencing. Bit ten takes the page bit on every load
		// except a return, so the target lands in page 000-3FF or 400-7FF.
		if (take) begin
			unique case (instr_in.pc_op)
				PC_HOLD: begin
				end
				PC_STEP: begin
					s_next.pc = pc_inc;
				end
				PC_JUMP: begin
					s_next.pc = {s_reg.pc[11], page,
						instr_in.operand};
				end
				PC_CALL: begin
					s_next.pc = {s_reg.pc[11], page,
						instr_in.operand};
					s_next.stk[s_reg.sp] = pc_inc;
					s_next.sp = s_reg.sp + SP_W'(1);
				end
				PC_RET: begin
					// Page select is left alone so the caller's page returns.
					s_next.pc = s_reg.stk[s_reg.sp - SP_W'(1)];
					s_next.sp = s_reg.sp - SP_W'(1);
				end
				PC_ADD: begin
					s_next.pc = s_reg.pc + 12'(instr_in.operand[7:0]);
					s_next.pc[10] = page;
				end
				default: begin
				end
			endcase
			if (cycle_opt_in && (instr_in.pc_op == PC_JUMP
				|| instr_in.pc_op == PC_CALL || instr_in.pc_op == PC_RET
				|| instr_in.pc_op == PC_ADD)) begin
				s_next.skip = 1'b1;
			end
		end

		// Register port writes.
		if (reg_req_in.wr) begin
			if (is_ctrl) begin
				if (tctrl_wr) begin
					s_next.tctrl = reg_req_in.wdata;
				end
			end else if (is_ram) begin
				s_next.ram[ram_idx] = reg_req_in.wdata;
			end else begin
				unique case (target)
					ADDR_TIMER: begin
						s_next.time_clock_counter = reg_req_in.wdata;
					end
					ADDR_PC_LOW: begin
						s_next.pc = {s_reg.pc[11], page, s_reg.pc[9:8],
							reg_req_in.wdata};
						s_next.skip = cycle_opt_in;
					end
					ADDR_STATUS: begin
						s_next.status = (s_reg.status & ~STATUS_WR_MASK)
							| (reg_req_in.wdata & STATUS_WR_MASK);
					end
					ADDR_RAM_SEL: begin
						s_next.ram_sel = reg_req_in.wdata & RAM_SEL_MASK;
					end
					default: begin
					end
				endcase
			end
		end

		// Prescaler clear on timer or timer control write.
		if (tcc_wr || tctrl_wr) begin
			s_next.psc = 8'h00;
		end

		// Hardware flag updates win over a software write in the same cycle.
		if (take && alu_in.valid) begin
			s_next.status[ST_Z] = alu_in.result == 8'h00;
			if (alu_in.is_add) begin
				s_next.status[ST_C]  = alu_in.carry7;
				s_next.status[ST_DC] = alu_in.carry3;
			end
		end
		if (take) begin
			unique case (instr_in.core_op)
				CORE_NONE: begin
				end
				CORE_SLEEP: begin
					s_next.status[ST_TO] = 1'b1;
					s_next.status[ST_PD] = 1'b0;
				end
				CORE_WDT_CLEAR: begin
					s_next.status[ST_TO] = 1'b1;
					s_next.status[ST_PD] = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// Read data stand for exactly one cycle after the strobe.
		s_next.rd_data = 8'h00;
		if (reg_req_in.rd) begin
			if (is_ctrl) begin
				if (!seg && ctrl_ofs == CTRL_TIMER_OFS) begin
					s_next.rd_data = s_reg.tctrl;
				end else if (seg && ctrl_ofs == CTRL_PSC_OFS) begin
					s_next.rd_data = s_reg.psc;
				end
			end else if (is_ram) begin
				s_next.rd_data = s_reg.ram[ram_idx];
			end else begin
				unique case (target)
					ADDR_TIMER: begin
						s_next.rd_data = s_reg.time_clock_counter;
					end
					ADDR_PC_LOW: begin
						s_next.rd_data = s_reg.pc[7:0];
					end
					ADDR_STATUS: begin
						s_next.rd_data = s_reg.status;
					end
					ADDR_RAM_SEL: begin
						s_next.rd_data = s_reg.ram_sel;
					end
					default: begin
						s_next.rd_data = 8'h00;
					end
				endcase
			end
		end

		// A non-power-on reset overrides everything it touches. It restarts
		// the cycle strobe so the first instruction sees a clean cycle.
		if (reset_event_in) begin
			s_next.pc   = 12'h000;
			s_next.psc  = 8'h00;
			s_next.skip = 1'b0;
			s_next.tick = 1'b0;
			s_next.div  = 2'h0;
			s_next.status[ST_WAKE] = reset_cause_in == RC_WAKE;
			if (reset_cause_in == RC_WATCHDOG) begin
				s_next.status[ST_TO] = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers.

	// Data memory contents are not reset; only control state is.
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			s_reg.pc       <= 12'h000;
			s_reg.stk      <= '0;
			s_reg.sp       <= '0;
			s_reg.status   <= STATUS_POR;
			s_reg.time_clock_counter      <= 8'h00;
			s_reg.psc      <= 8'h00;
			s_reg.tctrl    <= TCTRL_RESET;
			s_reg.ram_sel  <= 8'h00;
			s_reg.ram      <= s_next.ram;
			s_reg.rd_data  <= 8'h00;
			s_reg.div      <= 2'h0;
			s_reg.tick     <= 1'b0;
			s_reg.skip     <= 1'b0;
			s_reg.pin_prev <= 1'b0;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from state flops.

	assign rd_data_out     = s_reg.rd_data;
	assign cycle_tick_out  = s_reg.tick;
	assign prog_addr_out   = s_reg.pc[PROG_W-1:0];
	assign status_out      = s_reg.status;
	assign timer_value_out = s_reg.time_clock_counter;

endmodule : mcsr_core

// ### rtl/mcsr_pkg.sv
package mcsr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths and sizes.
	localparam int ADDR_W      = 7;
	localparam int DATA_W      = 8;
	localparam int PC_W        = 12;
	localparam int PROG_W      = 11;
	localparam int JUMP_W      = 10;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W        = $clog2(STACK_DEPTH);
	localparam int RAM_WORDS   = 80;
	localparam int RAM_IDX_W   = 7;

	////////////////////////////////////////////////////////////////////////
	// Register port address map.
	localparam logic [5:0] ADDR_INDIRECT  = 6'h00;
	localparam logic [5:0] ADDR_TIMER     = 6'h01;
	localparam logic [5:0] ADDR_PC_LOW    = 6'h02;
	localparam logic [5:0] ADDR_STATUS    = 6'h03;
	localparam logic [5:0] ADDR_RAM_SEL   = 6'h04;
	localparam logic [5:0] ADDR_GEN_BASE  = 6'h10;
	localparam logic [5:0] ADDR_BANK_BASE = 6'h20;
	localparam int         ADDR_CTRL_BIT  = 6;
	localparam logic [5:0] CTRL_TIMER_OFS = 6'h01;
	localparam logic [5:0] CTRL_PSC_OFS   = 6'h0C;

	localparam logic [RAM_IDX_W-1:0] GEN_WORDS  = 7'h10;
	localparam logic [RAM_IDX_W-1:0] BANK_WORDS = 7'h20;

	////////////////////////////////////////////////////////////////////////
	// Field positions, masks and reset values.
	localparam int ST_WAKE = 7;
	localparam int ST_SEG  = 6;
	localparam int ST_PAGE = 5;
	localparam int ST_TO   = 4;
	localparam int ST_PD   = 3;
	localparam int ST_Z    = 2;
	localparam int ST_DC   = 1;
	localparam int ST_C    = 0;
	localparam logic [7:0] STATUS_WR_MASK = 8'h67;
	localparam logic [7:0] STATUS_POR     = 8'h18;
	localparam logic [7:0] RAM_SEL_MASK   = 8'h7F;
	localparam int         RAM_SEL_BANK   = 6;
	localparam int         TC_SRC         = 5;
	localparam int         TC_EDGE        = 4;
	localparam int         TC_BYPASS      = 3;
	localparam logic [7:0] TCTRL_RESET    = 8'h00;
	localparam logic [1:0] DIV2_LAST      = 2'h1;
	localparam logic [1:0] DIV4_LAST      = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Commands and carriers.
	typedef enum logic [2:0] {
		PC_HOLD = 3'h0, PC_STEP = 3'h1, PC_JUMP = 3'h2,
		PC_CALL = 3'h3, PC_RET  = 3'h4, PC_ADD  = 3'h5
	} mcsr_pc_op_t;

	typedef enum logic [1:0] {
		CORE_NONE = 2'h0, CORE_SLEEP = 2'h1, CORE_WDT_CLEAR = 2'h2
	} mcsr_core_op_t;

	typedef enum logic [1:0] {
		RC_EXTERNAL = 2'h0, RC_WATCHDOG = 2'h1, RC_WAKE = 2'h2
	} mcsr_reset_cause_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} mcsr_reg_req_t;

	typedef struct packed {
		mcsr_pc_op_t       pc_op;
		logic [JUMP_W-1:0] operand;
		mcsr_core_op_t     core_op;
	} mcsr_instr_t;

	typedef struct packed {
		logic              valid;
		logic              is_add;
		logic [DATA_W-1:0] result;
		logic              carry7;
		logic              carry3;
	} mcsr_alu_t;

	typedef struct packed {
		logic [PC_W-1:0]                   pc;
		logic [STACK_DEPTH-1:0][PC_W-1:0]  stk;
		logic [SP_W-1:0]                   sp;
		logic [DATA_W-1:0]                 status;
		logic [DATA_W-1:0]                 time_clock_counter;
		logic [DATA_W-1:0]                 psc;
		logic [DATA_W-1:0]                 tctrl;
		logic [DATA_W-1:0]                 ram_sel;
		logic [RAM_WORDS-1:0][DATA_W-1:0]  ram;
		logic [DATA_W-1:0]                 rd_data;
		logic [1:0]                        div;
		logic                              tick;
		logic                              skip;
		logic                              pin_prev;
	} mcsr_state_t;

endpackage : mcsr_pkg

// ### sim/mcsr_core_props.sv
`timescale 1ns/1ps
module mcsr_core_props
	import mcsr_pkg::*;
(
	input wire logic              mclk_in,        // Clock
	input wire logic              rstn_in,        // Reset, low
	input wire mcsr_reg_req_t     reg_req_in,     // Register port
	input wire logic [DATA_W-1:0] rd_data_out,    // Read data
	input wire mcsr_instr_t       instr_in,       // Instruction
	input wire mcsr_alu_t         alu_in,         // Flag result
	input wire logic              reset_event_in, // Reset pulse
	input wire mcsr_reset_cause_t reset_cause_in, // Reset cause
	input wire logic              cycle_tick_out, // Cycle pulse
	input wire logic [PROG_W-1:0] prog_addr_out,  // Program address
	input wire logic [DATA_W-1:0] status_out,     // Status
	input wire logic [DATA_W-1:0] timer_value_out // Timer
);
	// A software write in the same cycle may also move the counter.
	logic take;
	assign take = cycle_tick_out && !reset_event_in && !reg_req_in.wr;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	////////////////////////////////////////////////////////////////////
	property p_rst_pc;
		reset_event_in |=> prog_addr_out == 11'h000;
	endproperty
	a_rst_pc: assert property (p_rst_pc) else $error("pc kept");
	property p_wake;
		reset_event_in |=>
			status_out[ST_WAKE] == ($past(reset_cause_in) == RC_WAKE);
	endproperty
	a_wake: assert property (p_wake) else $error("wake bit");
	property p_jump;
		take && instr_in.pc_op inside {PC_JUMP, PC_CALL} |=> prog_addr_out
			== {$past(status_out[ST_PAGE]), $past(instr_in.operand)};
	endproperty
	a_jump: assert property (p_jump) else $error("jump");
	property p_ret;
		take && instr_in.pc_op == PC_RET |=> $stable(status_out[ST_PAGE]);
	endproperty
	a_ret: assert property (p_ret) else $error("page moved");
	property p_add;
		take && instr_in.pc_op == PC_ADD |=> prog_addr_out == {
			$past(status_out[ST_PAGE]),
			10'($past(prog_addr_out[9:0]) + $past(instr_in.operand[7:0]))};
	endproperty
	a_add: assert property (p_add) else $error("add");
	property p_pcwr;
		reg_req_in.wr && reg_req_in.addr == {1'b0, ADDR_PC_LOW}
			&& !reset_event_in && !cycle_tick_out |=> prog_addr_out ==
			{$past(status_out[ST_PAGE]), $past(prog_addr_out[9:8]),
			$past(reg_req_in.wdata)};
	endproperty
	a_pcwr: assert property (p_pcwr) else $error("pc write");
	property p_tmr;
		reg_req_in.wr && reg_req_in.addr == {1'b0, ADDR_TIMER}
			|=> timer_value_out == $past(reg_req_in.wdata);
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer write");
	property p_sleep;
		take && instr_in.core_op == CORE_SLEEP
			|=> status_out[ST_TO:ST_PD] == 2'h2;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep");
	property p_watchdog_clear_instruction;
		take && instr_in.core_op == CORE_WDT_CLEAR
			|=> status_out[ST_TO:ST_PD] == 2'h3;
	endproperty
	a_watchdog_clear_instruction: assert property (p_watchdog_clear_instruction) else $error("clear");
	property p_zero;
		take && alu_in.valid
			|=> status_out[ST_Z] == ($past(alu_in.result) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero");
	property p_carry;
		take && alu_in.valid && alu_in.is_add |=> status_out[1:0] ==
			{$past(alu_in.carry3), $past(alu_in.carry7)};
	endproperty
	a_carry: assert property (p_carry) else $error("carry");
	property p_tick;
		cycle_tick_out |=> !cycle_tick_out;
	endproperty
	a_tick: assert property (p_tick) else $error("tick");
endmodule : mcsr_core_props
bind mcsr_core mcsr_core_props mcsr_core_props_i (.*);

// ### sim/mcsr_core_tb.sv
`timescale 1ns/1ps
module mcsr_core_tb;
	import mcsr_pkg::*;
	logic              mclk_in = 1'b0;
	logic              rstn_in = 1'b0;
	mcsr_reg_req_t     reg_req_in = '0;
	mcsr_instr_t       instr_in = '0;
	mcsr_alu_t         alu_in = '0;
	logic              reset_event_in = 1'b0;
	mcsr_reset_cause_t reset_cause_in = RC_EXTERNAL;
	logic              tcc_pin_in = 1'b0;
	logic              clk_div_sel_in = 1'b0;
	logic              cycle_opt_in = 1'b0;
	logic              cycle_tick_out;
	logic [DATA_W-1:0] rd_data_out, status_out, timer_value_out;
	logic [PROG_W-1:0] prog_addr_out;
	logic [7:0]        rq[$];
	logic [10:0]       pq[$];
	logic              rd_pend = 1'b0, pc_pend = 1'b0;
	int                miscompares = 0, compares = 0, cyc = 0;
	logic [7:0]        st, d;
	logic [10:0]       pc;
	mcsr_alu_t         a;
	mcsr_core_op_t     c;

	mcsr_core mcsr_core_i (.*);

	always #50 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////////
	task summarize;
		$display("compares %0d, miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task cmp(input logic [10:0] g, input logic [10:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h, want %h", $time, g, e);
		end
	endtask : cmp
	// A result shows one cycle after its request, so the note is ripe.
	always @(posedge mclk_in) begin
		if (rd_pend)
			cmp({3'b000, rd_data_out}, {3'b000, rq.pop_front()});
		if (pc_pend)
			cmp(prog_addr_out, pq.pop_front());
		rd_pend <= reg_req_in.rd;
		pc_pend <= reset_event_in || (cycle_tick_out
			&& instr_in.pc_op != PC_HOLD) || (reg_req_in.wr
			&& reg_req_in.addr == {1'b0, ADDR_PC_LOW});
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			summarize();
		end
	end
	task req(input logic w, r, input logic [6:0] ad, input logic [7:0] v);
		reg_req_in <= '{ad, v, w, r};
		@(posedge mclk_in);
		reg_req_in <= '0;
		@(posedge mclk_in);
	endtask : req
	task wr(input logic [6:0] ad, input logic [7:0] v);
		req(1'b1, 1'b0, ad, v);
	endtask : wr
	task rd(input logic [6:0] ad, input logic [7:0] e);
		rq.push_back(e);
		req(1'b0, 1'b1, ad, 8'h00);
	endtask : rd
	task ins(input mcsr_pc_op_t op, input logic [9:0] o,
		input mcsr_core_op_t co, input logic [10:0] e);
		instr_in <= '{op, o, co};
		if (op != PC_HOLD)
			pq.push_back(e);
		do @(posedge mclk_in); while (!cycle_tick_out);
		instr_in <= '{PC_HOLD, 10'h000, CORE_NONE};
		alu_in.valid <= 1'b0;
		// Let the idle values reach an edge before the next caller drives.
		@(posedge mclk_in);
	endtask : ins
	// Look at a standing output away from the edge that launches it.
	task look(input logic [7:0] g, input logic [7:0] e);
		@(negedge mclk_in);
		cmp({3'b000, g}, {3'b000, e});
		@(posedge mclk_in);
	endtask : look
	task pin(input logic v);
		tcc_pin_in <= v;
		repeat (2) @(posedge mclk_in);
	endtask : pin
	task done(input string s);
		$display("test %s finished", s);
	endtask : done
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(64));
		@(posedge mclk_in);
		clk_div_sel_in <= 1'($urandom);
		cycle_opt_in <= 1'($urandom);
		repeat (5) @(posedge mclk_in);
		rstn_in <= 1'b1;
		st = STATUS_POR;
		rd({1'b0, ADDR_STATUS}, st);
		rd({1'b0, ADDR_PC_LOW}, 8'h00);
		rd(7'h05, 8'h00);
		wr({1'b0, ADDR_RAM_SEL}, 8'hFF);
		rd({1'b0, ADDR_RAM_SEL}, 8'h7F);
		d = 8'($urandom);
		wr({1'b0, ADDR_RAM_SEL}, 8'h20);
		wr(7'h00, d);
		rd(7'h20, d);
		wr({1'b0, ADDR_RAM_SEL}, 8'h60);
		wr(7'h20, ~d);
		rd(7'h00, ~d);
		wr({1'b0, ADDR_RAM_SEL}, 8'h20);
		rd(7'h00, d);
		done("banking");
		wr(7'h41, 8'h28);
		wr({1'b0, ADDR_TIMER}, d);
		rd({1'b0, ADDR_TIMER}, d);
		repeat (3) begin
			pin(1'b1);
			pin(1'b0);
		end
		rd({1'b0, ADDR_TIMER}, d + 8'h03);
		wr(7'h41, 8'h38);
		pin(1'b1);
		pin(1'b0);
		rd({1'b0, ADDR_TIMER}, d + 8'h04);
		look(timer_value_out, d + 8'h04);
		// Ratio four keeps one edge in the prescaler before the timer write and before the control write.
		wr(7'h41, 8'h21);
		pin(1'b1);
		wr({1'b0, ADDR_STATUS}, 8'h40);
		rd(7'h41, 8'h00);
		rd(7'h4C, 8'h01);
		wr({1'b0, ADDR_TIMER}, d);
		rd(7'h4C, 8'h00);
		pin(1'b0);
		pin(1'b1);
		wr({1'b0, ADDR_STATUS}, 8'h00);
		rd(7'h41, 8'h21);
		wr(7'h41, 8'h21);
		wr({1'b0, ADDR_STATUS}, 8'h40);
		rd(7'h4C, 8'h00);
		done("timer");
		wr({1'b0, ADDR_STATUS}, 8'h20);
		pc = {1'b1, 10'($urandom_range(0, 1022))};
		ins(PC_JUMP, pc[9:0], CORE_NONE, pc);
		d = 8'($urandom);
		ins(PC_CALL, {2'b00, d}, CORE_NONE, {3'b100, d});
		wr({1'b0, ADDR_STATUS}, 8'h00);
		pc = pc + 11'h001;
		ins(PC_RET, 10'h000, CORE_NONE, pc);
		rd({1'b0, ADDR_STATUS}, st);
		d = 8'($urandom);
		pc = {1'b0, 10'(pc[9:0] + 10'(d))};
		ins(PC_ADD, {2'b00, d}, CORE_NONE, pc);
		d = 8'($urandom);
		pc = {1'b0, pc[9:8], d};
		pq.push_back(pc);
		wr({1'b0, ADDR_PC_LOW}, d);
		done("program counter");
		for (int k = 0; k < 3; k++) begin
			reset_cause_in <= mcsr_reset_cause_t'(k);
			reset_event_in <= 1'b1;
			pq.push_back(11'h000);
			@(posedge mclk_in);
			reset_event_in <= 1'b0;
			st[7] = (k == 2);
			if (k == 1)
				st[4] = 1'b0;
			rd({1'b0, ADDR_STATUS}, st);
		end
		done("reset causes");
		for (int k = 0; k < 6; k++) begin
			a = mcsr_alu_t'({1'b1, 11'($urandom)});
			if (k < 2)
				a.result = 8'h00;
			alu_in <= a;
			c = mcsr_core_op_t'(k % 3);
			if (a.is_add)
				st[1:0] = {a.carry3, a.carry7};
			st[2] = (a.result == 8'h00);
			if (c != CORE_NONE)
				st[4:3] = {1'b1, c == CORE_WDT_CLEAR};
			ins(PC_HOLD, 10'h000, c, 11'h000);
			rd({1'b0, ADDR_STATUS}, st);
			look(status_out, st);
		end
		done("flags");
		repeat (2) @(posedge mclk_in);
		summarize();
	end
endmodule : mcsr_core_tb
